/* File: design/rmtc_top.sv */
// run-mode controller: start, stop, delay and burst of waveform playback
// assumes synchronous command pulses and a playback engine that pulses
// cycle_done at the end of each waveform cycle

module rmtc_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic output_on,
  input wire logic cont_mode,
  input wire logic armed_mode,
  input wire logic [1:0] enab_src,
  input wire logic [1:0] trig_src,
  input wire logic [1:0] evt_slope,
  input wire logic [1:0] trig_slope,
  input wire logic width_qual_en,
  input wire logic [rmtc_pkg::WIDTH_W-1:0] trig_width,
  input wire logic [rmtc_pkg::DELAY_W-1:0] trig_delay,
  input wire logic [rmtc_pkg::DELAY_W-1:0] timer_delay,
  input wire logic [rmtc_pkg::BURST_W-1:0] burst_count,
  input wire logic [1:0] idle_cfg,
  input wire logic enable_req,
  input wire logic abort_req,
  input wire logic bus_trig_req,
  input wire logic evt_in,
  input wire logic trig_in,
  input wire logic cycle_done,
  output logic play_run,
  output logic play_idle,
  output logic play_restart,
  output logic [1:0] idle_sel,
  output logic wait_start
);
  typedef struct packed {
    rmtc_pkg::rmtc_state_t st;
    logic run;
    logic idle;
    logic restart;
    logic waiting;
    logic [1:0] idle_sel;
    logic [rmtc_pkg::DELAY_W-1:0] dly_cnt;
    logic [rmtc_pkg::DELAY_W-1:0] tmr_cnt;
    logic [rmtc_pkg::BURST_W-1:0] burst_cnt;
  } rmtc_top_t;
  rmtc_top_t s_ff;
  rmtc_top_t nxt_s;

  logic evt_lvl;
  logic evt_edge;
  logic trig_lvl;
  logic trig_edge;
  logic wq_pulse;
  logic trig_ext;
  logic trig_ev;
  logic enab_ev;
  logic fire;
  logic start_burst;
  logic [rmtc_pkg::DELAY_W-1:0] dly_val;
  logic [rmtc_pkg::DELAY_W-1:0] tmr_raw;
  logic [rmtc_pkg::DELAY_W-1:0] tmr_val;
  logic [rmtc_pkg::BURST_W-1:0] burst_val;

  ////////////////////////////////////////////////////////////////////////////
  // input qualification; each pin has its own slope select
  rmtc_edge_qual u_evt_qual (
    .sys_clk (sys_clk),
    .nrst (nrst),
    .sig_in (evt_in),
    .slope (evt_slope),
    .lvl (evt_lvl),
    .edge_pulse (evt_edge)
  );

  rmtc_edge_qual u_trig_qual (
    .sys_clk (sys_clk),
    .nrst (nrst),
    .sig_in (trig_in),
    .slope (trig_slope),
    .lvl (trig_lvl),
    .edge_pulse (trig_edge)
  );

  rmtc_width_qual u_width_qual (
    .sys_clk (sys_clk),
    .nrst (nrst),
    .lvl (trig_lvl),
    .en (width_qual_en),
    .width (trig_width),
    .qual_pulse (wq_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event routing and programmed values
  always_comb
  begin
    // event slope reaches the trigger path only through TRIG_SRC_EVT
    trig_ext = width_qual_en ? wq_pulse : trig_edge;
    if (trig_src == rmtc_pkg::TRIG_SRC_EXT)
      trig_ev = trig_ext;
    else if (trig_src == rmtc_pkg::TRIG_SRC_BUS)
      trig_ev = bus_trig_req;
    else if (trig_src == rmtc_pkg::TRIG_SRC_EVT)
      trig_ev = evt_edge;
    else
      trig_ev = 1'b0; // timer fires from its own state
    // only the selected enable source counts
    if (enab_src == rmtc_pkg::ENAB_SRC_BUS)
      enab_ev = enable_req;
    else if (enab_src == rmtc_pkg::ENAB_SRC_EVT)
      enab_ev = evt_edge;
    else if (enab_src == rmtc_pkg::ENAB_SRC_TRG)
      enab_ev = trig_ext;
    else
      enab_ev = 1'b0;
    // delays move in steps of eight samples
    dly_val = {trig_delay[rmtc_pkg::DELAY_W-1:3], 3'h0};
    if (dly_val > rmtc_pkg::TRIG_DELAY_MAX)
      dly_val = rmtc_pkg::TRIG_DELAY_MAX;
    tmr_raw = {timer_delay[rmtc_pkg::DELAY_W-1:3], 3'h0};
    if (tmr_raw < rmtc_pkg::TIMER_DELAY_MIN)
      tmr_val = rmtc_pkg::TIMER_DELAY_MIN;
    else if (tmr_raw > rmtc_pkg::TRIG_DELAY_MAX)
      tmr_val = rmtc_pkg::TRIG_DELAY_MAX;
    else
      tmr_val = tmr_raw;
    // zero reads as one, the top is clamped
    if (burst_count == '0)
      burst_val = rmtc_pkg::BURST_DEF;
    else if (burst_count > rmtc_pkg::BURST_MAX)
      burst_val = rmtc_pkg::BURST_MAX;
    else
      burst_val = burst_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // run-mode state machine
  always_comb
  begin
    nxt_s = s_ff;
    fire = 1'b0;
    start_burst = 1'b0;
    nxt_s.idle_sel = idle_cfg;
    if (!output_on)
      nxt_s.st = rmtc_pkg::ST_IDLE;
    else
    begin
      case (s_ff.st)
        rmtc_pkg::ST_IDLE:
        begin
          if (!cont_mode)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
          else if (armed_mode)
            nxt_s.st = rmtc_pkg::ST_WAIT_ARM;
          else
            nxt_s.st = rmtc_pkg::ST_RUN_CONT;
        end
        rmtc_pkg::ST_WAIT_ARM:
        begin
          if (!cont_mode || !armed_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (enab_ev)
            nxt_s.st = rmtc_pkg::ST_RUN_CONT;
        end
        rmtc_pkg::ST_RUN_CONT:
        begin
          // abort taken at once, no boundary wait; self-armed ignores it
          if (!cont_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (armed_mode && abort_req)
            nxt_s.st = rmtc_pkg::ST_WAIT_ARM;
          else if (!armed_mode && abort_req)
            nxt_s.st = rmtc_pkg::ST_RUN_CONT;
          else
            nxt_s.st = rmtc_pkg::ST_RUN_CONT;
        end
        rmtc_pkg::ST_WAIT_TRIG:
        begin
          // enable requests have no path into this state
          if (cont_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (abort_req)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
          else if (trig_src == rmtc_pkg::TRIG_SRC_TMR)
          begin
            nxt_s.st = rmtc_pkg::ST_TIMER;
            nxt_s.tmr_cnt = tmr_val - rmtc_pkg::DELAY_ONE;
          end
          else if (trig_ev)
            fire = 1'b1;
        end
        rmtc_pkg::ST_DELAY:
        begin
          if (cont_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (abort_req)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
          else if (s_ff.dly_cnt == '0)
            start_burst = 1'b1;
          else
            nxt_s.dly_cnt = s_ff.dly_cnt - rmtc_pkg::DELAY_ONE;
        end
        rmtc_pkg::ST_BURST:
        begin
          // further triggers are ignored while the burst plays
          if (cont_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (abort_req)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
          else if (cycle_done && s_ff.burst_cnt != '0)
            nxt_s.burst_cnt = s_ff.burst_cnt - rmtc_pkg::BURST_DEF;
          else if (cycle_done && trig_src == rmtc_pkg::TRIG_SRC_TMR)
          begin
            nxt_s.st = rmtc_pkg::ST_TIMER;
            nxt_s.tmr_cnt = tmr_val - rmtc_pkg::DELAY_ONE;
          end
          else if (cycle_done)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
        end
        rmtc_pkg::ST_TIMER:
        begin
          if (cont_mode)
            nxt_s.st = rmtc_pkg::ST_IDLE;
          else if (abort_req || trig_src != rmtc_pkg::TRIG_SRC_TMR)
            nxt_s.st = rmtc_pkg::ST_WAIT_TRIG;
          else if (s_ff.tmr_cnt == '0)
            fire = 1'b1;
          else
            nxt_s.tmr_cnt = s_ff.tmr_cnt - rmtc_pkg::DELAY_ONE;
        end
        default:
          nxt_s.st = rmtc_pkg::ST_IDLE;
      endcase
    end
    // a trigger goes through the delay unless the delay is zero
    if (fire && dly_val == '0)
      start_burst = 1'b1;
    else if (fire)
    begin
      nxt_s.st = rmtc_pkg::ST_DELAY;
      nxt_s.dly_cnt = dly_val - rmtc_pkg::DELAY_ONE;
    end
    if (start_burst)
    begin
      nxt_s.st = rmtc_pkg::ST_BURST;
      nxt_s.burst_cnt = burst_val - rmtc_pkg::BURST_DEF;
    end
    // outputs follow the next state so they leave straight from flops
    nxt_s.run = (nxt_s.st == rmtc_pkg::ST_RUN_CONT) ||
                (nxt_s.st == rmtc_pkg::ST_BURST);
    nxt_s.idle = output_on && !nxt_s.run;
    nxt_s.restart = nxt_s.run && !s_ff.run;
    nxt_s.waiting = (nxt_s.st == rmtc_pkg::ST_WAIT_ARM) ||
                    (nxt_s.st == rmtc_pkg::ST_WAIT_TRIG);
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign play_run = s_ff.run;
  assign play_idle = s_ff.idle;
  assign play_restart = s_ff.restart;
  assign idle_sel = s_ff.idle_sel;
  assign wait_start = s_ff.waiting;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_self_start: assert property (
    s_ff.st == rmtc_pkg::ST_IDLE && output_on && cont_mode && !armed_mode
    |=> play_run ##1 play_run || !$past(output_on))
    else $error("self-armed start did not run");
  a_armed_hold: assert property (
    s_ff.st == rmtc_pkg::ST_WAIT_ARM && !enab_ev |=> !play_run)
    else $error("armed mode ran without enable");
  a_abort_stop: assert property (
    s_ff.st == rmtc_pkg::ST_RUN_CONT && armed_mode && cont_mode &&
    output_on && abort_req |=> !play_run && play_idle && wait_start)
    else $error("armed abort did not stop output");
  a_abort_self: assert property (
    s_ff.st == rmtc_pkg::ST_RUN_CONT && !armed_mode && cont_mode &&
    output_on |=> play_run)
    else $error("self-armed output stopped");
  a_trig_abort: assert property (
    s_ff.st == rmtc_pkg::ST_BURST && !cont_mode && output_on &&
    abort_req |=> !play_run)
    else $error("triggered abort did not stop at once");
  a_idle_sel: assert property (
    play_idle |-> idle_sel == $past(idle_cfg))
    else $error("idle waveform select not tracked");
  a_burst_end: assert property (
    s_ff.st == rmtc_pkg::ST_BURST && cycle_done && s_ff.burst_cnt == '0 &&
    !abort_req && !cont_mode && output_on |=> !play_run)
    else $error("burst did not end on its last cycle");
  a_no_delay: assert property (
    s_ff.st == rmtc_pkg::ST_WAIT_TRIG && trig_ev && dly_val == '0 &&
    trig_src != rmtc_pkg::TRIG_SRC_TMR && !abort_req && !cont_mode &&
    output_on |=> play_run && play_restart)
    else $error("zero delay trigger did not start");
  a_delay_hold: assert property (
    s_ff.st == rmtc_pkg::ST_DELAY && s_ff.dly_cnt != '0 |=> !play_run)
    else $error("output ran during trigger delay");
  a_timer_min: assert property (
    $rose(s_ff.st == rmtc_pkg::ST_TIMER) |->
    s_ff.tmr_cnt >= rmtc_pkg::TIMER_DELAY_MIN - rmtc_pkg::DELAY_ONE)
    else $error("stop-to-start delay below minimum");
  a_enab_trig: assert property (
    s_ff.st == rmtc_pkg::ST_WAIT_TRIG && enable_req && !trig_ev
    |=> !play_run)
    else $error("enable started triggered mode");
  a_src_ignored: assert property (
    s_ff.st == rmtc_pkg::ST_WAIT_ARM && enab_src != rmtc_pkg::ENAB_SRC_BUS
    && !evt_edge && !trig_ext && enable_req |=> !play_run)
    else $error("unselected enable source acted");

  c_self_run: cover property (
    s_ff.st == rmtc_pkg::ST_IDLE ##1 s_ff.st == rmtc_pkg::ST_RUN_CONT);
  c_armed_abort: cover property (
    s_ff.st == rmtc_pkg::ST_RUN_CONT && armed_mode && abort_req);
  c_burst_done: cover property (
    s_ff.st == rmtc_pkg::ST_BURST ##1 s_ff.st == rmtc_pkg::ST_WAIT_TRIG);
  c_timer_fire: cover property (
    s_ff.st == rmtc_pkg::ST_TIMER ##1 s_ff.st == rmtc_pkg::ST_BURST);
endmodule

/* File: common/rmtc_pkg.sv */
// constants, encodings and state type of the run-mode trigger controller
// assumes one 100 MHz sample-side clock and synchronous active-low reset
package rmtc_pkg;
  // clock and time figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int WIDTH_MIN_NS = 10;
  localparam int WIDTH_MIN_CYC = (WIDTH_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int WIDTH_DEF_NS = 100000000;
  localparam int WIDTH_DEF_CYC = WIDTH_DEF_NS / CLK_PERIOD_NS;
  // field widths
  localparam int WIDTH_W = 28;
  localparam int DELAY_W = 23;
  localparam int BURST_W = 25;
  // counts and limits
  localparam logic [DELAY_W-1:0] TRIG_DELAY_DEF = 23'h000000;
  localparam logic [DELAY_W-1:0] TRIG_DELAY_MAX = 23'h7A1200;
  localparam logic [DELAY_W-1:0] TIMER_DELAY_MIN = 23'h000098;
  localparam logic [DELAY_W-1:0] DELAY_ONE = 23'h000001;
  localparam logic [BURST_W-1:0] BURST_DEF = 25'h0000001;
  localparam logic [BURST_W-1:0] BURST_MAX = 25'h1000000;
  localparam logic [WIDTH_W-1:0] WIDTH_ONE = 28'h0000001;
  // event and trigger slope encodings
  localparam logic [1:0] RISING_EDGE_SEL = 2'h0;
  localparam logic [1:0] FALLING_EDGE_SEL = 2'h1;
  localparam logic [1:0] BOTH_EDGES_SEL = 2'h2;
  // enable source encodings
  localparam logic [1:0] ENAB_SRC_BUS = 2'h0;
  localparam logic [1:0] ENAB_SRC_EVT = 2'h1;
  localparam logic [1:0] ENAB_SRC_TRG = 2'h2;
  // trigger source encodings
  localparam logic [1:0] TRIG_SRC_EXT = 2'h0;
  localparam logic [1:0] TRIG_SRC_BUS = 2'h1;
  localparam logic [1:0] TRIG_SRC_TMR = 2'h2;
  localparam logic [1:0] TRIG_SRC_EVT = 2'h3;
  // idle waveform encodings
  localparam logic [1:0] IDLE_DC = 2'h0;
  localparam logic [1:0] IDLE_FIRST_WAVE = 2'h1;
  localparam logic [1:0] IDLE_FIRST_SEQ = 2'h2;
  // controller states
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_WAIT_ARM,
    ST_RUN_CONT,
    ST_WAIT_TRIG,
    ST_DELAY,
    ST_BURST,
    ST_TIMER
  } rmtc_state_t;
endpackage

/* File: design/rmtc_edge_qual.sv */
// two-flop synchroniser and slope-selected edge detector for one input pin
// assumes the pin is asynchronous to sys_clk

module rmtc_edge_qual (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sig_in,
  input wire logic [1:0] slope,
  output logic lvl,
  output logic edge_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pulse;
  } rmtc_eq_t;
  rmtc_eq_t s_ff;
  rmtc_eq_t nxt_s;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // synchronise, then compare the synced level with its previous value
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = sig_in;
    nxt_s.s2 = s_ff.s1;
    nxt_s.prev = s_ff.s2;
    rise = s_ff.s2 & ~s_ff.prev;
    fall = ~s_ff.s2 & s_ff.prev;
    if (slope == rmtc_pkg::FALLING_EDGE_SEL)
      nxt_s.pulse = fall;
    else if (slope == rmtc_pkg::BOTH_EDGES_SEL)
      nxt_s.pulse = rise | fall;
    else
      nxt_s.pulse = rise;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign lvl = s_ff.s2;
  assign edge_pulse = s_ff.pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_slope_edge: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    edge_pulse |-> ($past(slope) == rmtc_pkg::BOTH_EDGES_SEL &&
                    $past(lvl) != $past(s_ff.prev)) ||
                   ($past(slope) == rmtc_pkg::FALLING_EDGE_SEL &&
                    $past(s_ff.prev) && !$past(lvl)) ||
                   ($past(slope) != rmtc_pkg::FALLING_EDGE_SEL &&
                    $past(slope) != rmtc_pkg::BOTH_EDGES_SEL &&
                    $past(lvl) && !$past(s_ff.prev)))
    else $error("edge pulse does not match slope");
  a_sync_delay: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $rose(lvl) |-> $past(sig_in, 2))
    else $error("level not delayed by two flops");
endmodule

/* File: design/rmtc_width_qual.sv */
// trigger pulse-width qualifier: one pulse once the level has been high
// for the programmed number of cycles; assumes a synced input level

module rmtc_width_qual (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic lvl,
  input wire logic en,
  input wire logic [rmtc_pkg::WIDTH_W-1:0] width,
  output logic qual_pulse
);
  typedef struct packed {
    logic [rmtc_pkg::WIDTH_W-1:0] cnt;
    logic done;
    logic pulse;
  } rmtc_wq_t;
  rmtc_wq_t s_ff;
  rmtc_wq_t nxt_s;
  logic [rmtc_pkg::WIDTH_W-1:0] cnt_inc;

  ////////////////////////////////////////////////////////////////////////////
  // count high cycles, fire once per high pulse at the programmed width
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.pulse = 1'b0;
    cnt_inc = s_ff.cnt + rmtc_pkg::WIDTH_ONE;
    if (!lvl || !en)
    begin
      nxt_s.cnt = '0;
      nxt_s.done = 1'b0;
    end
    else if (!s_ff.done)
    begin
      nxt_s.cnt = cnt_inc;
      if (cnt_inc >= width)
      begin
        nxt_s.pulse = 1'b1;
        nxt_s.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign qual_pulse = s_ff.pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_width_reached: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    qual_pulse |-> $past(lvl) && $past(en) && s_ff.cnt >= $past(width))
    else $error("width pulse before the programmed width");
endmodule

/* File: tb/rmtc_engine_model.sv */
// playback engine stand-in: pulses cycle_done once per waveform cycle
// assumes play_run and play_restart come from the controller on sys_clk
module rmtc_engine_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic play_run,
  input wire logic play_restart,
  input wire logic [7:0] period,
  output logic cycle_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////
  // count samples of the cycle; a short period answers promptly
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !play_run || play_restart)
    begin
      cnt_ff <= 8'h01;
      cycle_done <= 1'b0;
    end
    else
    begin
      cycle_done <= (cnt_ff == period);
      cnt_ff <= (cnt_ff == period) ? 8'h01 : cnt_ff + 8'h01;
    end
  end
endmodule

/* File: tb/rmtc_top_tb_top.sv */
// self-checking bench of the run-mode controller with an engine model
// assumes a 100 MHz clock and synchronous active-low reset
module rmtc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, nrst = 0, output_on = 0, cont_mode = 1;
  logic armed_mode = 0, width_qual_en = 0, enable_req = 0, abort_req = 0;
  logic bus_trig_req = 0, evt_in = 0, trig_in = 0, cycle_done;
  logic [1:0] enab_src = 2'h0, trig_src = 2'h1, evt_slope = 2'h0;
  logic [1:0] idle_cfg = 2'h0, idle_sel, trig_slope = 2'h0;
  logic [rmtc_pkg::WIDTH_W-1:0] trig_width = 28'h0000005;
  logic [rmtc_pkg::DELAY_W-1:0] trig_delay = 23'h000000;
  logic [rmtc_pkg::DELAY_W-1:0] timer_delay = 23'h000010;
  logic [rmtc_pkg::BURST_W-1:0] burst_count = 25'h0000001;
  logic [7:0] period = 8'h04;
  logic play_run, play_idle, play_restart, wait_start;
  int err_count = 0, total_checks = 0, cyc = 0, dcnt = 0, n, n0;
  ////////////////////////////////////////////////////////////////////////
  rmtc_top rmtc_top_inst (.sys_clk(sys_clk), .nrst(nrst),
    .output_on(output_on), .cont_mode(cont_mode), .armed_mode(armed_mode),
    .enab_src(enab_src), .trig_src(trig_src), .evt_slope(evt_slope),
    .trig_slope(trig_slope), .width_qual_en(width_qual_en),
    .trig_width(trig_width), .trig_delay(trig_delay),
    .timer_delay(timer_delay), .burst_count(burst_count),
    .idle_cfg(idle_cfg), .enable_req(enable_req), .abort_req(abort_req),
    .bus_trig_req(bus_trig_req), .evt_in(evt_in), .trig_in(trig_in),
    .cycle_done(cycle_done), .play_run(play_run), .play_idle(play_idle),
    .play_restart(play_restart), .idle_sel(idle_sel),
    .wait_start(wait_start));
  rmtc_engine_model rmtc_engine_model_inst (.sys_clk(sys_clk),
    .nrst(nrst), .play_run(play_run), .play_restart(play_restart),
    .period(period), .cycle_done(cycle_done));
  ////////////////////////////////////////////////////////////////////////
  // clock, cycle ceiling and count of waveform cycles played
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (play_run === 1'b1 && cycle_done === 1'b1)
      dcnt++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shared compare, wait and pulse helpers
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic wait_run(input logic v, input int lim, output int k);
    k = 0;
    while (play_run !== v && k < lim)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask
  // k bits: abort, enable, bus trigger
  task automatic pulse(input logic [2:0] k);
    @(posedge sys_clk);
    {abort_req, enable_req, bus_trig_req} <= k;
    @(posedge sys_clk);
    {abort_req, enable_req, bus_trig_req} <= 3'h0;
    #1;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_self;
    @(posedge sys_clk);
    output_on <= 1'b1;
    #1;
    wait_run(1'b1, 4, n);
    chk("self run", 8'h01, play_run);
    idle(20);
    pulse(3'h4);
    idle(3);
    chk("self abort", 8'h01, play_run);
  endtask
  task automatic t_armed;
    @(posedge sys_clk);
    armed_mode <= 1'b1;
    pulse(3'h4);
    idle(4);
    chk("armed hold", 8'h00, play_run);
    for (int c = 0; c < 3; c++)
    begin
      @(posedge sys_clk);
      idle_cfg <= 2'(c);
      pulse(3'h2);
      chk("enable run", 8'h01, play_run);
      idle(5);
      pulse(3'h4);
      chk("abort run", 8'h00, play_run);
      chk("abort idle", 8'h01, play_idle);
      chk("idle sel", 8'(c), idle_sel);
    end
  endtask
  task automatic t_evt;
    @(posedge sys_clk);
    enab_src <= rmtc_pkg::ENAB_SRC_EVT;
    pulse(3'h2);
    idle(4);
    chk("bus enable off", 8'h00, play_run);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge sys_clk);
      evt_slope <= 2'(s);
      evt_in <= 1'b1;
      idle(6);
      chk("event rise", 8'(s != 1), play_run);
      pulse(3'h4);
      @(posedge sys_clk);
      evt_in <= 1'b0;
      idle(6);
      chk("event fall", 8'(s != 0), play_run);
      pulse(3'h4);
    end
    // trigger pin as the enable source
    @(posedge sys_clk);
    enab_src <= rmtc_pkg::ENAB_SRC_TRG;
    trig_in <= 1'b1;
    idle(6);
    chk("trig enable src", 8'h01, play_run);
    pulse(3'h4);
    @(posedge sys_clk);
    trig_in <= 1'b0;
  endtask
  task automatic t_trig;
    @(posedge sys_clk);
    enab_src <= rmtc_pkg::ENAB_SRC_BUS;
    cont_mode <= 1'b0;
    idle(4);
    pulse(3'h2);
    idle(4);
    chk("trig enable", 8'h00, play_run);
    chk("trig wait", 8'h01, wait_start);
    for (int d = 0; d < 24; d += 8)
    begin
      @(posedge sys_clk);
      trig_delay <= 23'(d);
      pulse(3'h1);
      wait_run(1'b1, 40, n);
      chk("restart", 8'h01, play_restart);
      if (d == 0)
        n0 = n;
      chk("delay", 8'(d), 8'(n - n0));
      wait_run(1'b0, 40, n);
    end
    @(posedge sys_clk);
    burst_count <= 25'h0000003;
    trig_delay <= 23'h000000;
    period <= 8'h09;
    dcnt = 0;
    pulse(3'h1);
    wait_run(1'b0, 60, n);
    chk("burst", 8'h03, 8'(dcnt));
    // event pin as the trigger source
    @(posedge sys_clk);
    trig_src <= rmtc_pkg::TRIG_SRC_EVT;
    evt_in <= 1'b1;
    idle(6);
    chk("event trig", 8'h01, play_run);
    pulse(3'h4);
    @(posedge sys_clk);
    trig_src <= rmtc_pkg::TRIG_SRC_EXT;
    evt_in <= 1'b0;
  endtask
  task automatic t_width;
    // event slope must not change the trigger pin's slope
    @(posedge sys_clk);
    evt_slope <= rmtc_pkg::FALLING_EDGE_SEL;
    trig_in <= 1'b1;
    idle(6);
    chk("trig slope", 8'h01, play_run);
    pulse(3'h4);
    @(posedge sys_clk);
    trig_in <= 1'b0;
    idle(4);
    @(posedge sys_clk);
    trig_src <= rmtc_pkg::TRIG_SRC_EXT;
    width_qual_en <= 1'b1;
    burst_count <= 25'h0000100;
    trig_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    trig_in <= 1'b0;
    idle(8);
    chk("short pulse", 8'h00, play_run);
    @(posedge sys_clk);
    trig_in <= 1'b1;
    idle(12);
    chk("wide pulse", 8'h01, play_run);
    pulse(3'h4);
    chk("trig abort", 8'h00, play_run);
  endtask
  // timer source: short setting clamps to the minimum stop-to-start gap
  task automatic t_timer;
    @(posedge sys_clk);
    trig_src <= rmtc_pkg::TRIG_SRC_TMR;
    width_qual_en <= 1'b0;
    burst_count <= 25'h0000001;
    period <= 8'h04;
    trig_in <= 1'b0;
    wait_run(1'b1, 400, n);
    wait_run(1'b0, 40, n);
    wait_run(1'b1, 400, n);
    chk("timer gap", 8'(rmtc_pkg::TIMER_DELAY_MIN), 8'(n));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset for six cycles, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_self;
    t_armed;
    t_evt;
    t_trig;
    t_width;
    t_timer;
    report_and_stop;
  end
endmodule
